// *** verilog/msc_mode_strap_config.v ***
// mode strap configuration loader: strap decode, latch and control bits
`timescale 1ns/100ps
`include "msc_consts.vh"
// What this block does
// - capture decoded mode straps into registers at power-up
// - four-level strap gives display-ID and aux audio
// - eight-level strap gives override, cable, load
// - display-ID select picks remote or local EDID
// - aux audio adds the auxiliary channel
// - override hands HDMI control to external
// - cable type selects twisted pair or cable_type_select
// - remote load copies remote EDID to SRAM
// - display-ID select stored at 0x4F bit 0
// - audio, load, override stored in 0x54
// - cable type stored at 0x5B bit 7
// - enabled pll reset follows frequency change
// - tolerate bounded spread-spectrum input clocks
// - single link pixel clock limits by receiver
// - target address chosen from eight strap levels
module msc_mode_strap_config
(
  input wire ref_clk,
  input wire rst_n,
  input wire [1:0] mode_lvl0,
  input wire [2:0] mode_lvl1,
  input wire [2:0] address_select_strap,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire rem_addr_wr,
  input wire [7:0] rem_addr_wdata,
  input wire remote_id_found,
  input wire freq_changed,
  input wire legacy_receiver,
  input wire pclk_over_max,
  input wire pclk_over_legacy,
  output reg display_id_disable_q,
  output reg audio_mode_q,
  output reg remote_display_id_load_q,
  output reg external_control_bit_q,
  output reg coaxial_mode_bit_q,
  output reg pll_reset_on_freq_change_q,
  output reg [7:0] bridge_control_reg_q,
  output reg [7:0] bridge_cfg_reg_q,
  output reg [7:0] link_control_reg_q,
  output reg [7:0] remote_id_addr_q,
  output reg use_remote_id_q,
  output reg use_local_id_q,
  output reg copy_remote_id_q,
  output reg aux_audio_en_q,
  output reg ext_hdmi_ctl_q,
  output reg pll_reset_q,
  output reg pclk_fault_q,
  output reg [6:0] target_addr_q,
  output reg loaded_q
);
  // ==========================================================
  // strap decode
  wire disp_sel_d;
  wire aux_d;
  wire ext_d;
  wire cable_d;
  wire rload_d;
  // level index minus one already arrives from the quantizer
  assign disp_sel_d = mode_lvl0[1];
  assign aux_d = mode_lvl0[0];
  assign ext_d = mode_lvl1[2];
  assign cable_d = mode_lvl1[1];
  assign rload_d = mode_lvl1[0];

  // ==========================================================
  // one-shot load after reset release
  reg load_q;
  wire load_d;
  assign load_d = ~loaded_q;
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      load_q <= 1'b0;
      loaded_q <= 1'b0;
    end
    else
    begin
      load_q <= load_d & ~load_q;
      if (load_q)
        loaded_q <= 1'b1;
    end
  end

  // ==========================================================
  // register write decode
  reg wr_ctl;
  reg wr_cfg;
  reg wr_link;
  // only the three strap-backed offsets answer; anything else is dropped
  always @*
  begin
    wr_ctl = 1'b0;
    wr_cfg = 1'b0;
    wr_link = 1'b0;
    if (reg_wr)
    begin
      if (reg_addr == `MSC_BRIDGE_CONTROL_OFS)
        wr_ctl = 1'b1;
      else if (reg_addr == `MSC_BRIDGE_CFG_OFS)
        wr_cfg = 1'b1;
      else if (reg_addr == `MSC_LINK_CTL_OFS)
        wr_link = 1'b1;
    end
  end

  wire ctl_b0;
  wire cfg_b1;
  wire cfg_b5;
  wire cfg_b7;
  wire link_b7;
  msc_reg_bit #(.RST_VAL(1'b0)) u_disp
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(load_q),
    .strap(disp_sel_d),
    .wr_en(wr_ctl),
    .wr_val(reg_wdata[`MSC_DISP_ID_DIS_BIT]),
    .bit_q(ctl_b0)
  );
  msc_reg_bit #(.RST_VAL(1'b0)) u_aux
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(load_q),
    .strap(aux_d),
    .wr_en(wr_cfg),
    .wr_val(reg_wdata[`MSC_AUDIO_MODE_BIT]),
    .bit_q(cfg_b1)
  );
  msc_reg_bit #(.RST_VAL(1'b0)) u_rload
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(load_q),
    .strap(rload_d),
    .wr_en(wr_cfg),
    .wr_val(reg_wdata[`MSC_REM_LOAD_BIT]),
    .bit_q(cfg_b5)
  );
  msc_reg_bit #(.RST_VAL(1'b0)) u_ext
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(load_q),
    .strap(ext_d),
    .wr_en(wr_cfg),
    .wr_val(reg_wdata[`MSC_EXT_OVERRIDE_BIT]),
    .bit_q(cfg_b7)
  );
  msc_reg_bit #(.RST_VAL(1'b0)) u_cable_type_select
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(load_q),
    .strap(cable_d),
    .wr_en(wr_link),
    .wr_val(reg_wdata[`MSC_CABLE_TYPE_SELECT_BIT]),
    .bit_q(link_b7)
  );

  // ==========================================================
  // remaining register bits, plain storage
  // full bytes are kept so read-back of spare bits returns what software wrote
  reg [7:0] ctl_rest_q;
  reg [7:0] cfg_rest_q;
  reg [7:0] link_rest_q;
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctl_rest_q <= `MSC_BRIDGE_CONTROL_RST;
      cfg_rest_q <= `MSC_BRIDGE_CFG_RST;
      link_rest_q <= `MSC_LINK_CTL_RST; // pll reset enabled until host clears it
      remote_id_addr_q <= `MSC_REM_ADDR_RST;
    end
    else
    begin
      if (wr_ctl)
        ctl_rest_q <= reg_wdata;
      if (wr_cfg)
        cfg_rest_q <= reg_wdata;
      if (wr_link)
        link_rest_q <= reg_wdata;
      if (rem_addr_wr)
        remote_id_addr_q <= rem_addr_wdata;
    end
  end

  wire [7:0] ctl_v;
  wire [7:0] cfg_v;
  wire [7:0] link_v;
  assign ctl_v = {ctl_rest_q[7:1], ctl_b0};
  assign cfg_v = {cfg_b7, cfg_rest_q[6], cfg_b5, cfg_rest_q[4:2], cfg_b1, cfg_rest_q[0]};
  assign link_v = {link_b7, link_rest_q[6:0]};

  // ==========================================================
  // decoded behaviour, all registered outputs
  // views are registered copies, so a write shows two edges after its strobe
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      display_id_disable_q <= 1'b0;
      audio_mode_q <= 1'b0;
      remote_display_id_load_q <= 1'b0;
      external_control_bit_q <= 1'b0;
      coaxial_mode_bit_q <= 1'b0;
      pll_reset_on_freq_change_q <= 1'b1;
      bridge_control_reg_q <= `MSC_BRIDGE_CONTROL_RST;
      bridge_cfg_reg_q <= `MSC_BRIDGE_CFG_RST;
      link_control_reg_q <= `MSC_LINK_CTL_RST;
    end
    else
    begin
      display_id_disable_q <= ctl_v[`MSC_DISP_ID_DIS_BIT];
      audio_mode_q <= cfg_v[`MSC_AUDIO_MODE_BIT];
      remote_display_id_load_q <= cfg_v[`MSC_REM_LOAD_BIT];
      external_control_bit_q <= cfg_v[`MSC_EXT_OVERRIDE_BIT];
      coaxial_mode_bit_q <= link_v[`MSC_CABLE_TYPE_SELECT_BIT];
      pll_reset_on_freq_change_q <= link_v[`MSC_PLL_RST_BIT];
      bridge_control_reg_q <= ctl_v;
      bridge_cfg_reg_q <= cfg_v;
      link_control_reg_q <= link_v;
    end
  end

  // ==========================================================
  // display ID path selection
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      use_remote_id_q <= 1'b0;
      use_local_id_q <= 1'b0;
      copy_remote_id_q <= 1'b0;
    end
    else
    begin
      // remote search first; local fallback is the caller's when none is found
      use_remote_id_q <= ~ctl_v[`MSC_DISP_ID_DIS_BIT] & remote_id_found;
      use_local_id_q <= ctl_v[`MSC_DISP_ID_DIS_BIT];
      copy_remote_id_q <= cfg_v[`MSC_REM_LOAD_BIT] & remote_id_found;
    end
  end

  // ==========================================================
  // audio channel and hdmi control hand-over
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aux_audio_en_q <= 1'b0;
      ext_hdmi_ctl_q <= 1'b0;
    end
    else
    begin
      // both follow the live register bits, so a software write acts two edges after its strobe
      aux_audio_en_q <= cfg_v[`MSC_AUDIO_MODE_BIT];
      ext_hdmi_ctl_q <= cfg_v[`MSC_EXT_OVERRIDE_BIT];
    end
  end

  // ==========================================================
  // link pll reset and pixel clock limits
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pll_reset_q <= 1'b0;
      pclk_fault_q <= 1'b0;
    end
    else
    begin
      // freq_changed is judged upstream with spread-spectrum margin applied
      pll_reset_q <= link_v[`MSC_PLL_RST_BIT] & freq_changed;
      pclk_fault_q <= legacy_receiver ? pclk_over_legacy : pclk_over_max;
    end
  end

  // ==========================================================
  // control bus target address
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      target_addr_q <= `MSC_TGT_ADDR_BASE;
    end
    else
    begin
      // the strap is read every cycle, so a divider changed in service moves the address
      target_addr_q <= `MSC_TGT_ADDR_BASE + {3'h0, address_select_strap, 1'b0};
    end
  end
endmodule

// *** verilog/msc_consts.vh ***
// constants for the mode strap configuration loader
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH
// register offsets
`define MSC_BRIDGE_CONTROL_OFS 8'h4F
`define MSC_BRIDGE_CFG_OFS 8'h54
`define MSC_LINK_CTL_OFS 8'h5B
// field positions
`define MSC_DISP_ID_DIS_BIT 0
`define MSC_AUDIO_MODE_BIT 1
`define MSC_REM_LOAD_BIT 5
`define MSC_EXT_OVERRIDE_BIT 7
`define MSC_PLL_RST_BIT 5
`define MSC_CABLE_TYPE_SELECT_BIT 7
// reset values
`define MSC_BRIDGE_CONTROL_RST 8'h00
`define MSC_BRIDGE_CFG_RST 8'h00
`define MSC_LINK_CTL_RST 8'h20
`define MSC_REM_ADDR_RST 8'hA0
// strap level widths
`define MSC_LVL0_W 2
`define MSC_LVL1_W 3
// control bus target address for address-select level 1, step of two per level
`define MSC_TGT_ADDR_BASE 7'h0C
// clock and frequency limits
`define MSC_CLK_MHZ 250
`define MSC_SS_DEV_PERMILLE 25
`define MSC_SS_MOD_KHZ 100
`define MSC_SS_MOD_CYC ((`MSC_CLK_MHZ * 1000) / `MSC_SS_MOD_KHZ)
`define MSC_PCLK_MAX_MHZ 96
`define MSC_PCLK_OLD_MHZ 85
`endif

// *** verilog/msc_reg_bit.v ***
// one writable control bit loaded once from a strap
`timescale 1ns/100ps
module msc_reg_bit
#(
  parameter RST_VAL = 1'b0
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire load,
  input wire strap,
  input wire wr_en,
  input wire wr_val,
  output reg bit_q
);
  // software write wins over the one-shot load
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      bit_q <= RST_VAL;
    else if (wr_en)
      bit_q <= wr_val;
    else if (load)
      bit_q <= strap;
  end
endmodule

// *** dv/msc_strap_divider.sv ***
// board divider model: turns a strap level number (1-based) into the quantized index
`timescale 1ns/100ps
module msc_strap_divider
(
  input wire [2:0] sel0_level,
  input wire [3:0] sel1_level,
  input wire [3:0] addr_level,
  output wire [1:0] mode_lvl0,
  output wire [2:0] mode_lvl1,
  output wire [2:0] address_select_strap
);
  // levels are assumed already quantized; divider tolerance is not modelled
  wire [2:0] idx0 = sel0_level - 3'h1;
  wire [3:0] idx1 = sel1_level - 4'h1;
  wire [3:0] idxa = addr_level - 4'h1;
  assign mode_lvl0 = idx0[1:0];
  assign mode_lvl1 = idx1[2:0];
  assign address_select_strap = idxa[2:0];
endmodule

// *** dv/msc_mode_strap_config_assertions.sv ***
// concurrent checks on the strap loader ports
`timescale 1ns/100ps
module msc_checker
(
  input wire ref_clk,
  input wire rst_n,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire display_id_disable_q,
  input wire audio_mode_q,
  input wire remote_display_id_load_q,
  input wire external_control_bit_q,
  input wire coaxial_mode_bit_q,
  input wire pll_reset_on_freq_change_q,
  input wire [7:0] bridge_control_reg_q,
  input wire [7:0] bridge_cfg_reg_q,
  input wire [7:0] link_control_reg_q,
  input wire [7:0] remote_id_addr_q,
  input wire [6:0] target_addr_q,
  input wire loaded_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_link_wr;
    reg_wr && reg_addr == 8'h5B;
  endsequence
  property p_link_write;
    s_link_wr |-> ##2 link_control_reg_q == $past(reg_wdata, 2);
  endproperty
  property p_reset_vals;
    disable iff (1'b0) !rst_n |=> remote_id_addr_q == 8'hA0 && link_control_reg_q == 8'h20;
  endproperty
  property p_tgt_range;
    !target_addr_q[0] && target_addr_q >= 7'h0C && target_addr_q <= 7'h1A;
  endproperty
  a_dis_mirror: assert property (display_id_disable_q == bridge_control_reg_q[0])
    else $error("display id disable differs from its register bit");
  a_audio_bit_mirror: assert property (audio_mode_q == bridge_cfg_reg_q[1])
    else $error("audio mode differs from its register bit");
  a_rld_mirror: assert property (remote_display_id_load_q == bridge_cfg_reg_q[5])
    else $error("remote load differs from its register bit");
  a_ext_bit_mirror: assert property (external_control_bit_q == bridge_cfg_reg_q[7])
    else $error("override differs from its register bit");
  a_cable_type_select_bit_mirror: assert property (coaxial_mode_bit_q == link_control_reg_q[7])
    else $error("coaxial_mode_bit differs from its register bit");
  a_pll_mirror: assert property (pll_reset_on_freq_change_q == link_control_reg_q[5])
    else $error("pll reset enable differs from its register bit");
  a_link_write_lands: assert property (p_link_write)
    else $error("link control write did not land");
  a_loaded_stays: assert property (loaded_q |=> loaded_q)
    else $error("load flag dropped without reset");
  a_reset_values: assert property (p_reset_vals)
    else $error("reset values wrong");
  a_target_range: assert property (p_tgt_range)
    else $error("target address outside the eight values");
endmodule
bind msc_mode_strap_config msc_checker i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .display_id_disable_q(display_id_disable_q),
  .audio_mode_q(audio_mode_q), .remote_display_id_load_q(remote_display_id_load_q),
  .external_control_bit_q(external_control_bit_q), .coaxial_mode_bit_q(coaxial_mode_bit_q),
  .pll_reset_on_freq_change_q(pll_reset_on_freq_change_q),
  .bridge_control_reg_q(bridge_control_reg_q), .bridge_cfg_reg_q(bridge_cfg_reg_q),
  .link_control_reg_q(link_control_reg_q), .remote_id_addr_q(remote_id_addr_q),
  .target_addr_q(target_addr_q), .loaded_q(loaded_q));

// *** dv/msc_mode_strap_config_tb.sv ***
// self-checking bench for the strap loader
`timescale 1ns/100ps
module msc_mode_strap_config_tb;
  reg ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, rem_addr_wr = 1'b0, found = 1'b0;
  reg freq_chg = 1'b0, legacy = 1'b0, over_max = 1'b0, over_leg = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rem_wdata = 8'h00;
  reg [2:0] s0 = 3'h1;
  reg [3:0] s1 = 4'h1, sa = 4'h1;
  wire [1:0] l0;
  wire [2:0] l1, la;
  wire dis, aud, rld, ext, cox, pen, urem, uloc, cpy, aux, xhd, prst, pflt, ldd;
  wire [7:0] bctl, bcfg, lctl, radr;
  wire [6:0] tgt;
  integer fails = 0, total_checks = 0, i;
  msc_strap_divider i_div (.sel0_level(s0), .sel1_level(s1), .addr_level(sa), .mode_lvl0(l0),
    .mode_lvl1(l1), .address_select_strap(la));
  msc_mode_strap_config i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .mode_lvl0(l0), .mode_lvl1(l1),
    .address_select_strap(la), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .rem_addr_wr(rem_addr_wr), .rem_addr_wdata(rem_wdata), .remote_id_found(found),
    .freq_changed(freq_chg), .legacy_receiver(legacy), .pclk_over_max(over_max),
    .pclk_over_legacy(over_leg), .display_id_disable_q(dis), .audio_mode_q(aud),
    .remote_display_id_load_q(rld), .external_control_bit_q(ext), .coaxial_mode_bit_q(cox),
    .pll_reset_on_freq_change_q(pen), .bridge_control_reg_q(bctl), .bridge_cfg_reg_q(bcfg),
    .link_control_reg_q(lctl), .remote_id_addr_q(radr), .use_remote_id_q(urem),
    .use_local_id_q(uloc), .copy_remote_id_q(cpy), .aux_audio_en_q(aux), .ext_hdmi_ctl_q(xhd),
    .pll_reset_q(prst), .pclk_fault_q(pflt), .target_addr_q(tgt), .loaded_q(ldd));
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
        fails = fails + 1;
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      cyc(3);
    end
  endtask
  task do_reset(input integer n);
    begin
      @(posedge ref_clk);
      rst_n <= 1'b0;
      cyc(n);
      rst_n <= 1'b1;
      cyc(5);
    end
  endtask
  // every code of both mode straps and of the address strap
  task t_straps;
    for (i = 0; i < 8; i = i + 1)
    begin
      s0 <= i % 4 + 1;
      s1 <= i + 1;
      sa <= i + 1;
      do_reset(2);
      chk("bctl", bctl, {7'h00, s0 > 3'h2});
      chk("bcfg", bcfg, {i[2], 1'b0, i[0], 3'h0, ~s0[0], 1'b0});
      chk("lctl", lctl, {i[1], 2'h1, 5'h00});
      chk("tgt", {1'b0, tgt}, 8'h0C + 2 * i);
      chk("loaded", ldd, 8'h01);
    end
  endtask
  // software writes, an unmapped offset, and straps moving after the load
  task t_writes;
    begin
      wr(8'h5B, 8'h80);
      chk("pll_en", pen, 8'h00);
      chk("cable_type_select", cox, 8'h01);
      s1 <= 4'h1;
      wr(8'h50, 8'hFF);
      chk("lctl", lctl, 8'h80);
      chk("bcfg", bcfg, 8'hA2);
      wr(8'h54, 8'h82);
      chk("aux", aux, 8'h01);
      chk("xhd", xhd, 8'h01);
      chk("rld", rld, 8'h00);
      chk("aud", aud, 8'h01);
      chk("ext", ext, 8'h01);
      wr(8'h4F, 8'h00);
      chk("uloc", uloc, 8'h00);
      chk("dis", dis, 8'h00);
      wr(8'h4F, 8'h01);
      chk("uloc", uloc, 8'h01);
      chk("dis", dis, 8'h01);
    end
  endtask
  // derived controls: edid path, pll reset, pixel clock limits, remote address
  task t_derived;
    begin
      s0 <= 3'h1;
      do_reset(1);
      chk("radr", radr, 8'hA0);
      found <= 1'b1;
      freq_chg <= 1'b1;
      legacy <= 1'b1;
      over_leg <= 1'b1;
      cyc(4);
      chk("urem", urem, 8'h01);
      chk("prst", prst, 8'h01);
      chk("pflt", pflt, 8'h01);
      chk("cpy", cpy, 8'h00);
      legacy <= 1'b0;
      wr(8'h54, 8'h20);
      chk("cpy", cpy, 8'h01);
      chk("pflt", pflt, 8'h00);
      wr(8'h5B, 8'h00);
      chk("prst", prst, 8'h00);
      rem_addr_wr <= 1'b1;
      rem_wdata <= 8'hB4;
      over_max <= 1'b1;
      @(posedge ref_clk);
      rem_addr_wr <= 1'b0;
      cyc(3);
      chk("radr", radr, 8'hB4);
      chk("pflt", pflt, 8'h01);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #40000;
    fails = fails + 1;
    wrap_up;
  end
  initial
  begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(5);
    t_straps;
    t_writes;
    t_derived;
    wrap_up;
  end
endmodule
